// ---- common/lcd_instr_pkg.sv ----
package lcd_instr_pkg;

	// Register byte addresses
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_MODE   = 4'h8;
	localparam logic [3:0] ADDR_DROPS  = 4'hc;

	// Control register fields
	localparam int          CTRL_SER_BIT  = 0;
	localparam int          CTRL_DIV_LSB  = 8;
	localparam logic [7:0]  OSC_DIV_RESET = 8'h04;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Execution lengths in oscillator cycles
	localparam logic [7:0] CLEAR_CYCLES = 8'ha5;
	localparam logic [7:0] STD_CYCLES   = 8'h03;

	// Host command codes and masks
	localparam logic [7:0] CODE_NOP    = 8'h00;
	localparam logic [7:0] CODE_CLEAR  = 8'h01;
	localparam logic [7:0] CODE_HOME   = 8'h02;
	localparam logic [7:0] MASK_ENTRY  = 8'hfc;
	localparam logic [7:0] CODE_ENTRY  = 8'h04;
	localparam logic [7:0] MASK_DISP   = 8'hf8;
	localparam logic [7:0] CODE_DISP   = 8'h08;
	localparam logic [7:0] MASK_SHIFT  = 8'hf3;
	localparam logic [7:0] CODE_SHIFT  = 8'h10;
	localparam logic [7:0] MASK_FUNC   = 8'he8;
	localparam logic [7:0] CODE_FUNC   = 8'h20;
	localparam logic [7:0] MASK_GLYPH  = 8'hc0;
	localparam logic [7:0] CODE_GLYPH  = 8'h40;
	localparam logic [7:0] BLANK_CHAR  = 8'h20;

	// Reset values of the configuration bits
	localparam logic       RST_INCREMENT = 1'b1;
	localparam logic       RST_BUS_WIDTH = 1'b1;
	localparam logic [1:0] RST_PUMP      = 2'h2;
	localparam logic [6:0] RST_DRIVE     = 7'h00;

	localparam int TEXT_DEPTH  = 128;
	localparam int GLYPH_DEPTH = 64;

	typedef enum logic [3:0]
	{
		INS_IGNORE,
		INS_NOP,
		INS_FUNC,
		INS_CLEAR,
		INS_HOME,
		INS_ENTRY,
		INS_DISP,
		INS_SHIFT,
		INS_GLYPH,
		INS_TEXT
	} instr_type;

	typedef enum logic
	{
		SER_CONTROL,
		SER_COMMAND
	} ser_phase_type;

endpackage

// ---- design/lcd_instruction_decoder.sv ----
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module lcd_instruction_decoder
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// Host parallel port
	input  wire logic        hostStrobe,
	input  wire logic        hostRegSel,
	input  wire logic        hostRead,
	input  wire logic [7:0]  hostDataIn,
	output logic      [7:0]  hostDataOut,
	output logic             hostDataOe,
	// Display state
	output logic             powerDown,
	output logic             cursorOn,
	output logic             cursorBlink,
	output logic      [4:0]  displayShift,
	output logic             twoLineMode,
	// AXI4-Lite slave
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic      [1:0]  s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	function automatic lcd_instr_pkg::instr_type decodeCmd(input logic [7:0] c, input logic ext);
		lcd_instr_pkg::instr_type t;
		t = lcd_instr_pkg::INS_IGNORE;
		if (c == lcd_instr_pkg::CODE_NOP)
			t = lcd_instr_pkg::INS_NOP;
		else if ((c & lcd_instr_pkg::MASK_FUNC) == lcd_instr_pkg::CODE_FUNC)
			t = lcd_instr_pkg::INS_FUNC;
		else if (!ext)
		begin
			if (c[7])
				t = lcd_instr_pkg::INS_TEXT;
			else if ((c & lcd_instr_pkg::MASK_GLYPH) == lcd_instr_pkg::CODE_GLYPH)
				t = lcd_instr_pkg::INS_GLYPH;
			else if ((c & lcd_instr_pkg::MASK_SHIFT) == lcd_instr_pkg::CODE_SHIFT)
				t = lcd_instr_pkg::INS_SHIFT;
			else if ((c & lcd_instr_pkg::MASK_DISP) == lcd_instr_pkg::CODE_DISP)
				t = lcd_instr_pkg::INS_DISP;
			else if ((c & lcd_instr_pkg::MASK_ENTRY) == lcd_instr_pkg::CODE_ENTRY)
				t = lcd_instr_pkg::INS_ENTRY;
			else if (c == lcd_instr_pkg::CODE_HOME)
				t = lcd_instr_pkg::INS_HOME;
			else if (c == lcd_instr_pkg::CODE_CLEAR)
				t = lcd_instr_pkg::INS_CLEAR;
		end
		return t;
	endfunction

	function automatic logic [6:0] stepPtr(input logic [6:0] p, input logic up);
		return up ? 7'(p + 7'h01) : 7'(p - 7'h01);
	endfunction

	// Display window wraps at 32 columns, or 16 with two lines
	function automatic logic [4:0] stepShift(input logic [4:0] s, input logic right,
		input logic two);
		logic [4:0] n;
		n = right ? 5'(s + 5'h01) : 5'(s - 5'h01);
		return two ? {1'b0, n[3:0]} : n;
	endfunction

	// Link synchronisers; stage one feeds only stage two
	logic        strobe1_ff, strobe2_ff, strobe3_ff;
	logic        rs1_ff, rs2_ff, rw1_ff, rw2_ff;
	logic [7:0]  db1_ff, db2_ff;

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			strobe1_ff <= 1'b0;
			strobe2_ff <= 1'b0;
			strobe3_ff <= 1'b0;
			rs1_ff     <= 1'b0;
			rs2_ff     <= 1'b0;
			rw1_ff     <= 1'b0;
			rw2_ff     <= 1'b0;
			db1_ff     <= 8'h00;
			db2_ff     <= 8'h00;
		end
		else
		begin
			strobe1_ff <= hostStrobe;
			strobe2_ff <= strobe1_ff;
			strobe3_ff <= strobe2_ff;
			rs1_ff     <= hostRegSel;
			rs2_ff     <= rs1_ff;
			rw1_ff     <= hostRead;
			rw2_ff     <= rw1_ff;
			db1_ff     <= hostDataIn;
			db2_ff     <= db1_ff;
		end
	end

	// Configuration and state registers
	logic        serMode_ff;
	logic [7:0]  oscDiv_ff;
	lcd_instr_pkg::ser_phase_type serPhase_ff;
	logic        serRs_ff, serMore_ff;
	logic        increment_ff, entryShift_ff;
	logic        dispOn_ff, cursor_ff, blink_ff;
	logic        busWidth_ff, twoLine_ff, muxNine_ff, extSet_ff;
	logic        iconOnly_ff, iconFlash_ff, directDrive_ff;
	logic        screenCfg_ff, colOrder_ff, rowOrder_ff;
	logic        tempOne_ff, tempTwo_ff;
	logic [1:0]  pumpStage_ff;
	logic [6:0]  driveA_ff, driveB_ff;
	logic [6:0]  ptr_ff;
	logic        ptrGlyph_ff;
	logic [4:0]  shift_ff;
	logic [7:0]  busyCnt_ff;
	logic [7:0]  oscCnt_ff;
	logic        clearing_ff;
	logic [6:0]  clrIdx_ff;
	logic [31:0] drops_ff;
	logic [7:0]  dataOut_ff;
	logic        dataOe_ff;

	logic [7:0]  textRam [lcd_instr_pkg::TEXT_DEPTH];
	logic [7:0]  glyphRam [lcd_instr_pkg::GLYPH_DEPTH];

	logic        busy, oscTick, strobeRise, strobeFall, hostRs;
	logic        wrEvt, ctlEvt, rdEvt, statusRd, dataRd, dataWr, cmdWr, dropEvt;
	logic        cfgWrite;
	lcd_instr_pkg::instr_type ins;

	assign busy       = busyCnt_ff != 8'h00;
	assign oscTick    = oscCnt_ff == 8'h00;
	assign strobeRise = strobe2_ff && !strobe3_ff;
	assign strobeFall = !strobe2_ff && strobe3_ff;
	// Serial mode keeps the register target from the control byte
	assign hostRs     = serMode_ff ? serRs_ff : rs2_ff;
	assign ctlEvt     = strobeRise && !rw2_ff && serMode_ff
		&& serPhase_ff == lcd_instr_pkg::SER_CONTROL;
	assign wrEvt      = strobeRise && !rw2_ff && !ctlEvt;
	assign rdEvt      = strobeRise && rw2_ff;
	assign statusRd   = rdEvt && !hostRs;
	assign dataRd     = rdEvt && hostRs && !busy;
	assign dataWr     = wrEvt && hostRs && !busy;
	assign cmdWr      = wrEvt && !hostRs && !busy;
	assign dropEvt    = (wrEvt || (rdEvt && hostRs)) && busy;
	assign ins        = cmdWr ? decodeCmd(db2_ff, extSet_ff) : lcd_instr_pkg::INS_IGNORE;

	// Oscillator derived from the system clock
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			oscCnt_ff <= lcd_instr_pkg::OSC_DIV_RESET - 8'h01;
		else if (cfgWrite || oscTick || dataWr || dataRd || cmdWr)
			oscCnt_ff <= oscDiv_ff - 8'h01;
		else
			oscCnt_ff <= oscCnt_ff - 8'h01;
	end

	// Busy counter restarts the oscillator so the count is whole cycles
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			busyCnt_ff <= lcd_instr_pkg::CLEAR_CYCLES;
		else if (ins == lcd_instr_pkg::INS_CLEAR)
			busyCnt_ff <= lcd_instr_pkg::CLEAR_CYCLES;
		else if (dataWr || dataRd || (ins != lcd_instr_pkg::INS_IGNORE))
			busyCnt_ff <= lcd_instr_pkg::STD_CYCLES;
		else if (busy && oscTick)
			busyCnt_ff <= busyCnt_ff - 8'h01;
	end

	// Text blanking walk, shorter than the busy window at any divider
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			clearing_ff <= 1'b1;
			clrIdx_ff   <= 7'h00;
		end
		else if (ins == lcd_instr_pkg::INS_CLEAR)
		begin
			clearing_ff <= 1'b1;
			clrIdx_ff   <= 7'h00;
		end
		else if (clearing_ff)
		begin
			clrIdx_ff   <= 7'(clrIdx_ff + 7'h01);
			clearing_ff <= clrIdx_ff != 7'h7f;
		end
	end

	always_ff @(posedge clk)
	begin
		if (clearing_ff)
			textRam[clrIdx_ff] <= lcd_instr_pkg::BLANK_CHAR;
		else if (dataWr && !ptrGlyph_ff)
			textRam[ptr_ff] <= db2_ff;
	end

	always_ff @(posedge clk)
	begin
		if (dataWr && ptrGlyph_ff)
			glyphRam[ptr_ff[5:0]] <= db2_ff;
	end

	// Serial framing: control byte, then command byte
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			serPhase_ff <= lcd_instr_pkg::SER_CONTROL;
			serRs_ff    <= 1'b0;
			serMore_ff  <= 1'b0;
		end
		else if (cfgWrite)
			serPhase_ff <= lcd_instr_pkg::SER_CONTROL;
		else if (ctlEvt)
		begin
			serMore_ff  <= db2_ff[7];
			serRs_ff    <= db2_ff[6];
			serPhase_ff <= lcd_instr_pkg::SER_COMMAND;
		end
		else if (wrEvt && serMode_ff && serMore_ff)
			serPhase_ff <= lcd_instr_pkg::SER_CONTROL;
	end

	// Instruction effects on mode bits
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			increment_ff  <= lcd_instr_pkg::RST_INCREMENT;
			entryShift_ff <= 1'b0;
			dispOn_ff     <= 1'b0;
			cursor_ff     <= 1'b0;
			blink_ff      <= 1'b0;
			busWidth_ff   <= lcd_instr_pkg::RST_BUS_WIDTH;
			twoLine_ff    <= 1'b0;
			muxNine_ff    <= 1'b0;
			extSet_ff     <= 1'b0;
		end
		else
			case (ins)
				lcd_instr_pkg::INS_FUNC:
				begin
					busWidth_ff <= db2_ff[4];
					twoLine_ff  <= db2_ff[2];
					muxNine_ff  <= db2_ff[1];
					extSet_ff   <= db2_ff[0];
				end
				lcd_instr_pkg::INS_ENTRY:
				begin
					increment_ff  <= db2_ff[1];
					entryShift_ff <= db2_ff[0];
				end
				lcd_instr_pkg::INS_DISP:
				begin
					dispOn_ff <= db2_ff[2];
					cursor_ff <= db2_ff[1];
					blink_ff  <= db2_ff[0];
				end
				default:
				begin
					increment_ff <= increment_ff;
				end
			endcase
	end

	// Extended-set fields keep their reset state; no writer here
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			iconOnly_ff    <= 1'b0;
			iconFlash_ff   <= 1'b0;
			directDrive_ff <= 1'b0;
			screenCfg_ff   <= 1'b0;
			colOrder_ff    <= 1'b0;
			rowOrder_ff    <= 1'b0;
			tempOne_ff     <= 1'b0;
			tempTwo_ff     <= 1'b0;
			driveA_ff      <= lcd_instr_pkg::RST_DRIVE;
			driveB_ff      <= lcd_instr_pkg::RST_DRIVE;
			pumpStage_ff   <= lcd_instr_pkg::RST_PUMP;
		end
	end

	// Address pointer and display shift
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ptr_ff      <= 7'h00;
			ptrGlyph_ff <= 1'b0;
			shift_ff    <= 5'h00;
		end
		else if (dataWr || dataRd)
		begin
			ptr_ff <= stepPtr(ptr_ff, increment_ff);
			if (entryShift_ff && !ptrGlyph_ff)
				shift_ff <= stepShift(shift_ff, !increment_ff, twoLine_ff);
		end
		else
			case (ins)
				lcd_instr_pkg::INS_CLEAR, lcd_instr_pkg::INS_HOME:
				begin
					ptr_ff      <= 7'h00;
					ptrGlyph_ff <= 1'b0;
					shift_ff    <= 5'h00;
				end
				lcd_instr_pkg::INS_SHIFT:
				begin
					if (db2_ff[3])
						shift_ff <= stepShift(shift_ff, db2_ff[2], twoLine_ff);
					else
						ptr_ff <= stepPtr(ptr_ff, db2_ff[2]);
				end
				lcd_instr_pkg::INS_GLYPH:
				begin
					ptr_ff      <= {ptr_ff[6], db2_ff[5:0]};
					ptrGlyph_ff <= 1'b1;
				end
				lcd_instr_pkg::INS_TEXT:
				begin
					ptr_ff      <= db2_ff[6:0];
					ptrGlyph_ff <= 1'b0;
				end
				default:
				begin
					ptr_ff <= ptr_ff;
				end
			endcase
	end

	// Read-back to the host, driven until the strobe falls
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			dataOut_ff <= 8'h00;
			dataOe_ff  <= 1'b0;
		end
		else if (statusRd)
		begin
			dataOut_ff <= {busy, ptr_ff};
			dataOe_ff  <= 1'b1;
		end
		else if (dataRd)
		begin
			dataOut_ff <= ptrGlyph_ff ? glyphRam[ptr_ff[5:0]] : textRam[ptr_ff];
			dataOe_ff  <= 1'b1;
		end
		else if (strobeFall)
			dataOe_ff <= 1'b0;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			drops_ff <= 32'h0000_0000;
		else if (dropEvt)
			drops_ff <= drops_ff + 32'h0000_0001;
	end

	assign hostDataOut  = dataOut_ff;
	assign hostDataOe   = dataOe_ff;
	assign powerDown    = !dispOn_ff;
	assign cursorOn     = cursor_ff;
	assign cursorBlink  = blink_ff;
	assign displayShift = shift_ff;
	assign twoLineMode  = twoLine_ff;

	// AXI4-Lite: address and data may arrive in either order
	logic        awHeld_ff, wHeld_ff, bvalid_ff, rvalid_ff;
	logic [3:0]  awAddr_ff, wStrb_ff;
	logic [31:0] wData_ff, rdata_ff;
	logic [1:0]  bresp_ff, rresp_ff;
	logic        doWrite;

	assign s_axi_awready = !awHeld_ff && !bvalid_ff;
	assign s_axi_wready  = !wHeld_ff && !bvalid_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;
	assign doWrite       = awHeld_ff && wHeld_ff && !bvalid_ff;
	assign cfgWrite      = doWrite && awAddr_ff == lcd_instr_pkg::ADDR_CTRL;

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			awHeld_ff <= 1'b0;
			wHeld_ff  <= 1'b0;
			awAddr_ff <= 4'h0;
			wData_ff  <= 32'h0000_0000;
			wStrb_ff  <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff  <= lcd_instr_pkg::RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awHeld_ff <= 1'b1;
				awAddr_ff <= {s_axi_awaddr[3:2], 2'h0};
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wHeld_ff <= 1'b1;
				wData_ff <= s_axi_wdata;
				wStrb_ff <= s_axi_wstrb;
			end
			if (doWrite)
			begin
				awHeld_ff <= 1'b0;
				wHeld_ff  <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff  <= cfgWrite ? lcd_instr_pkg::RESP_OKAY : lcd_instr_pkg::RESP_SLVERR;
			end
			else if (bvalid_ff && s_axi_bready)
				bvalid_ff <= 1'b0;
		end
	end

	// Control register: serial framing select and oscillator divider
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			serMode_ff <= 1'b0;
			oscDiv_ff  <= lcd_instr_pkg::OSC_DIV_RESET;
		end
		else if (cfgWrite)
		begin
			if (wStrb_ff[0])
				serMode_ff <= wData_ff[lcd_instr_pkg::CTRL_SER_BIT];
			// A zero divider would reload the count with 255 and give a 256-cycle oscillator, so it is refused
			if (wStrb_ff[1] && wData_ff[lcd_instr_pkg::CTRL_DIV_LSB +: 8] != 8'h00)
				oscDiv_ff <= wData_ff[lcd_instr_pkg::CTRL_DIV_LSB +: 8];
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= lcd_instr_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_ff <= 1'b1;
			rresp_ff  <= lcd_instr_pkg::RESP_OKAY;
			case ({s_axi_araddr[3:2], 2'h0})
				lcd_instr_pkg::ADDR_CTRL:
					rdata_ff <= {16'h0000, oscDiv_ff, 7'h00, serMode_ff};
				lcd_instr_pkg::ADDR_STATUS:
					rdata_ff <= {8'h00, busyCnt_ff, 2'h0, shift_ff, ptrGlyph_ff, busy, ptr_ff};
				lcd_instr_pkg::ADDR_MODE:
					rdata_ff <= {driveB_ff[5:0], driveA_ff, pumpStage_ff, tempTwo_ff, tempOne_ff,
						rowOrder_ff, colOrder_ff, screenCfg_ff, directDrive_ff,
						iconFlash_ff, iconOnly_ff, extSet_ff, muxNine_ff, twoLine_ff,
						busWidth_ff, blink_ff, cursor_ff, dispOn_ff, entryShift_ff,
						increment_ff};
				lcd_instr_pkg::ADDR_DROPS:
					rdata_ff <= drops_ff;
				default:
				begin
					rdata_ff <= 32'h0000_0000;
					rresp_ff <= lcd_instr_pkg::RESP_SLVERR;
				end
			endcase
		end
		else if (rvalid_ff && s_axi_rready)
			rvalid_ff <= 1'b0;
	end

endmodule

// ---- testbench/host_bus_model.sv ----
`timescale 1ns/1ps
module host_bus_model
(
	// Host port
	output logic            hostStrobe,
	output logic            hostRegSel,
	output logic            hostRead,
	output logic      [7:0] hostDataIn,
	// Device answer
	input  wire logic [7:0] hostDataOut,
	input  wire logic       hostDataOe
);
	initial
	begin
		hostStrobe = 1'b0;
		hostRegSel = 1'b0;
		hostRead = 1'b0;
		hostDataIn = 8'ha5;
	end

	// Odd start offset keeps strobe edges off the system clock edges
	task automatic xfer(input logic rs, input logic rw, input logic [7:0] d,
		output logic [7:0] q, output logic oe);
		#7;
		hostRegSel = rs;
		hostRead = rw;
		hostDataIn = d;
		#100 hostStrobe = 1'b1;
		#100 hostStrobe = 1'b0;
		#50;
		q = hostDataOut;
		oe = hostDataOe;
		// Released lines must not keep the last byte
		hostDataIn = ~d;
	endtask
endmodule

// ---- testbench/lcd_decoder_properties.sv ----
`timescale 1ns/1ps
module lcd_decoder_properties
(
	// Clock and reset
	input wire logic       clk,
	input wire logic       sys_rst,
	// Host port
	input wire logic       hostStrobe,
	input wire logic       hostRegSel,
	input wire logic       hostRead,
	input wire logic       hostDataOe,
	// Display state
	input wire logic       powerDown,
	input wire logic       cursorOn,
	input wire logic       cursorBlink,
	input wire logic [4:0] displayShift,
	input wire logic       twoLineMode,
	// Register bus
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_reset_state:
	assert property ($fell(sys_rst) |-> powerDown && !cursorOn && !cursorBlink && !twoLineMode
		&& displayShift == 5'h00) else $error("display state after reset wrong");
	a_read_drives:
	assert property ($rose(hostDataOe) |-> hostRead) else $error("port driven on a write");
	// Status reads are answered even while busy
	a_status_answer:
	assert property ($rose(hostStrobe) && hostRead && !hostRegSel |-> ##[2:6] hostDataOe)
		else $error("status read not answered");
	a_oe_release:
	assert property ($fell(hostStrobe) |-> ##[1:5] !hostDataOe) else $error("port not released");
	a_config_write:
	assert property ($changed({powerDown, cursorOn, cursorBlink, twoLineMode}) |-> !hostRead)
		else $error("display state changed by a read");
	a_shift_step:
	assert property ($changed(displayShift) && displayShift != 5'h00 && $stable(twoLineMode)
		|-> 5'(displayShift - $past(displayShift)) inside {5'h01, 5'h1f}
		|| (twoLineMode && 5'(displayShift - $past(displayShift)) == 5'h0f))
		else $error("shift moved by more than one");
	a_shift_range:
	assert property (twoLineMode && $changed(displayShift) |-> displayShift < 5'h10)
		else $error("shift beyond a two-line row");
	a_bresp_time:
	assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid) else $error("write response late");
	a_bvalid_hold:
	assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_read_answer:
	assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
	a_rdata_hold:
	assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_ar_refused:
	assert property (s_axi_rvalid |-> !s_axi_arready) else $error("address taken while busy");

	c_host_read: cover property ($rose(hostDataOe));
	c_shift: cover property ($changed(displayShift));
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
	c_two_line: cover property ($rose(twoLineMode));
endmodule

bind lcd_instruction_decoder lcd_decoder_properties u_props (.clk, .sys_rst, .hostStrobe,
	.hostRegSel, .hostRead, .hostDataOe, .powerDown, .cursorOn, .cursorBlink, .displayShift,
	.twoLineMode, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready);

// ---- testbench/test_lcd_instruction_decoder.sv ----
`timescale 1ns/1ps
module test_lcd_instruction_decoder;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        hostStrobe, hostRegSel, hostRead, hostDataOe, hOe;
	logic        powerDown, cursorOn, cursorBlink, twoLineMode;
	logic [7:0]  hostDataIn, hostDataOut, hb;
	logic [4:0]  displayShift;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	int          err_total = 0, checks_done = 0;
	int          ram[128], gram[64];
	int          ptr = 0, inc = 1, esh = 0, sh = 0, two = 0, gly = 0, ext = 0, r;
	real         t;

	always #12.5 clk = ~clk;

	lcd_instruction_decoder uut (.clk, .sys_rst, .hostStrobe, .hostRegSel, .hostRead,
		.hostDataIn, .hostDataOut, .hostDataOe, .powerDown, .cursorOn, .cursorBlink,
		.displayShift, .twoLineMode, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	host_bus_model u_host (.hostStrobe, .hostRegSel, .hostRead, .hostDataIn, .hostDataOut,
		.hostDataOe);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("checks=%0d errors=%0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic timedOut();
		err_total++;
		results();
	endtask

	task automatic wr32(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		if (n == 50) timedOut();
		chk(s_axi_bresp, er);
	endtask

	task automatic rd32(input logic [3:0] a, output logic [31:0] d);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		if (n == 50) timedOut();
		d = s_axi_rdata;
		chk(s_axi_rresp, lcd_instr_pkg::RESP_OKAY);
	endtask

	// Bounded poll of the busy bit before the next instruction
	task automatic idle();
		for (int n = 0; n < 400; n++)
		begin
			rd32(lcd_instr_pkg::ADDR_STATUS, q);
			if (q[7] === 1'b0) return;
		end
		timedOut();
	endtask

	task automatic host(input logic rs, input logic rw, input logic [7:0] d);
		u_host.xfer(rs, rw, d, hb, hOe);
		@(posedge clk);
	endtask

	function automatic int m();
		return two ? 16 : 32;
	endfunction

	task automatic step();
		if (gly)
			ptr = (ptr & 64) | ((ptr + (inc ? 1 : 63)) & 63);
		else
		begin
			ptr = (ptr + (inc ? 1 : 127)) & 127;
			if (esh) sh = (sh + (inc ? m() - 1 : 1)) % m();
		end
	endtask

	task automatic stat();
		rd32(lcd_instr_pkg::ADDR_STATUS, q);
		chk(q[6:0], ptr);
		chk(q[8], gly);
		chk(displayShift, sh);
		chk(twoLineMode, two);
	endtask

	task automatic fin(input logic [7:0] c);
		idle();
		if (ext && c[7:5] != 3'h1) ;
		else if (c == 8'h01)
		begin
			foreach (ram[i]) ram[i] = 32;
			ptr = 0;
			sh = 0;
			gly = 0;
		end
		else if (c == 8'h02)
		begin
			ptr = 0;
			sh = 0;
			gly = 0;
		end
		else if (c[7:2] == 6'h01)
		begin
			inc = c[1];
			esh = c[0];
		end
		else if (c[7:4] == 4'h1 && c[3]) sh = (sh + (c[2] ? 1 : m() - 1)) % m();
		else if (c[7:4] == 4'h1) ptr = (ptr + (c[2] ? 1 : 127)) & 127;
		else if (c[7:5] == 3'h1)
		begin
			two = c[2];
			ext = c[0];
		end
		else if (c[7:6] == 2'h1)
		begin
			ptr = (ptr & 64) | c[5:0];
			gly = 1;
		end
		else if (c[7])
		begin
			ptr = c[6:0];
			gly = 0;
		end
		stat();
	endtask

	task automatic cmd(input logic [7:0] c);
		host(1'b0, 1'b0, c);
		fin(c);
	endtask

	task automatic wrd(input logic [7:0] d);
		host(1'b1, 1'b0, d);
		idle();
		if (gly) gram[ptr & 63] = d;
		else ram[ptr] = d;
		step();
		stat();
	endtask

	task automatic rdd();
		host(1'b1, 1'b1, 8'h00);
		chk(hb, gly ? gram[ptr & 63] : ram[ptr]);
		idle();
		step();
		stat();
	endtask

	initial
	begin
		void'($urandom(32'h246d44fb));
		foreach (ram[i]) ram[i] = 32;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		t = $realtime;
		rd32(lcd_instr_pkg::ADDR_STATUS, q);
		chk(q[7], 1'b1);
		chk(q[23:16] > 8'd163, 1'b1);
		rd32(lcd_instr_pkg::ADDR_MODE, q);
		chk(q[8:0], 9'h021);
		chk(q[16:9], 8'h00);
		chk(q[31:17], 15'h0002);
		chk({powerDown, cursorOn, cursorBlink, twoLineMode, displayShift}, 9'h100);
		host(1'b0, 1'b1, 8'h00);
		chk({hOe, hb[7]}, 2'h3);
		host(1'b1, 1'b1, 8'h00);
		chk(hOe, 1'b0);
		host(1'b1, 1'b0, 8'h41);
		rd32(lcd_instr_pkg::ADDR_DROPS, q);
		chk(q, 32'h2);
		idle();
		chk($realtime - t > 16400.0, 1'b1);
		// Divider of one makes oscillator cycles equal clock cycles
		wr32(lcd_instr_pkg::ADDR_CTRL, 32'h0000_0100, lcd_instr_pkg::RESP_OKAY);
		wr32(lcd_instr_pkg::ADDR_STATUS, 32'h0, lcd_instr_pkg::RESP_SLVERR);
		rd32(lcd_instr_pkg::ADDR_CTRL, q);
		chk(q, 32'h0000_0100);
		cmd(8'h85);
		repeat (4) wrd(8'($urandom));
		cmd(8'h04);
		repeat (2) wrd(8'($urandom));
		cmd(8'h85);
		cmd(8'h06);
		repeat (4) rdd();
		host(1'b0, 1'b0, 8'h01);
		rd32(lcd_instr_pkg::ADDR_STATUS, q);
		t = $realtime;
		r = q[23:16];
		chk(r > 150, 1'b1);
		rd32(lcd_instr_pkg::ADDR_STATUS, q);
		chk(r - q[23:16], int'(($realtime - t) / 25.0));
		host(1'b0, 1'b0, 8'h0f);
		chk(powerDown, 1'b1);
		fin(8'h01);
		rdd();
		for (int i = 8; i < 16; i++)
		begin
			cmd(8'(i));
			chk({powerDown, cursorOn, cursorBlink}, {~i[2], i[1:0]});
		end
		cmd(8'h02);
		cmd(8'h07);
		wrd(8'h5a);
		cmd(8'h05);
		wrd(8'ha5);
		for (int i = 0; i < 4; i++) cmd(8'h10 | 8'(i << 2));
		cmd(8'h36);
		rd32(lcd_instr_pkg::ADDR_MODE, q);
		chk(q[7:5], 3'h7);
		cmd(8'h18);
		cmd(8'h31);
		cmd(8'h02);
		cmd(8'h30);
		cmd(8'h06);
		cmd(8'h02);
		cmd(8'h80);
		rdd();
		cmd(8'h52);
		wrd(8'h3c);
		cmd(8'h52);
		rdd();
		wr32(lcd_instr_pkg::ADDR_CTRL, 32'h0000_0101, lcd_instr_pkg::RESP_OKAY);
		host(1'b0, 1'b0, 8'h80);
		cmd(8'h8a);
		host(1'b0, 1'b0, 8'h40);
		wrd(8'h77);
		wr32(lcd_instr_pkg::ADDR_CTRL, 32'h0000_0100, lcd_instr_pkg::RESP_OKAY);
		cmd(8'h8a);
		rdd();
		results();
	end
endmodule
